// >>> design/ahid_pkg.sv
package ahid_pkg;

  // register bus geometry
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;

  // register offsets (word index on the plain port)
  localparam logic [3:0] OFF_SLOT12 = 4'h0;
  localparam logic [3:0] OFF_SLOT345 = 4'h1;
  localparam logic [3:0] OFF_POWER = 4'h2;
  localparam logic [3:0] OFF_STATUS = 4'h3;

  // reset values
  localparam logic [15:0] RST_ID = 16'h0000;
  localparam logic [15:0] RST_RDATA = 16'h0000;

  // slot345 accessory layout
  localparam int ACC_SLOT3_LSB = 8;
  localparam int ACC_PLC_BIT = 7;
  localparam int ACC_MEM_BIT = 6;
  localparam int ACC_FB_LSB = 4;
  localparam logic [3:0] ACC_LOW_FIXED = 4'h0;
  localparam logic [1:0] FB_NONE = 2'h0;
  localparam logic [1:0] FB_ACTIVE = 2'h1;
  localparam logic [1:0] FB_PASSIVE = 2'h2;

  // power hardware layout
  localparam int PWR_TOP_LSB = 13;
  localparam logic [2:0] PWR_TOP_FIXED = 3'h6;
  localparam int PWR_BRAKE_BIT = 12;
  localparam int PWR_DCSPEC_BIT = 11;
  localparam int PWR_CONV24_BIT = 10;
  localparam int PWR_RELAY_BIT = 9;
  localparam int PWR_RFI_BIT = 8;
  localparam int PWR_VOLT_LSB = 6;
  localparam int PWR_CUR_LSB = 0;
  localparam logic [1:0] VOLT_LOW = 2'h0;
  localparam logic [1:0] VOLT_MID = 2'h1;

  // status register layout
  localparam int STAT_DONE_BIT = 0;

  typedef enum logic [1:0] {
    AHID_ST_START = 2'b00,
    AHID_ST_HOLD = 2'b01
  } ahid_state_t;

  // accessory presence, as detected on the control module
  typedef struct packed {
    logic [7:0] slot1_code;
    logic [7:0] slot2_code;
    logic [7:0] slot3_code;
    logic plc_fitted;
    logic mem_fitted;
    logic [1:0] fieldbus_type;
  } ahid_accy_t;

  // power hardware presence
  typedef struct packed {
    logic brake_fitted;
    logic dc_special;
    logic conv24_fitted;
    logic relay_fitted;
    logic rfi_fitted;
    logic [1:0] volt_class;
    logic [5:0] current_code;
  } ahid_power_t;

  // register bus request
  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } ahid_bus_t;

endpackage

// >>> design/ahid_regs.sv
// Chosen here: the strobed register port and the address map.
`timescale 1ns/1ps
module ahid_regs (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // presence detection
  input wire ahid_pkg::ahid_accy_t accy_in,
  input wire ahid_pkg::ahid_power_t power_in,
  // register port
  input wire ahid_pkg::ahid_bus_t bus_in,
  output logic [15:0] rdata
);

  ahid_pkg::ahid_state_t state_r, state_nxt;
  logic [15:0] slot12_r, slot12_nxt;
  logic [15:0] slot345_r, slot345_nxt;
  logic [15:0] power_r, power_nxt;
  logic [15:0] rdata_r, rdata_nxt;

  // only the two documented fieldbus kinds reach the register
  function automatic logic [1:0] fb_code(input logic [1:0] kind);
    if (kind == ahid_pkg::FB_ACTIVE || kind == ahid_pkg::FB_PASSIVE) begin
      fb_code = kind;
    end else begin
      fb_code = ahid_pkg::FB_NONE;
    end
  endfunction

  // capture logic: one sample after reset release, then frozen so that a
  // module plugged in while running cannot change what software sees
  always_comb begin
    state_nxt = state_r;
    slot12_nxt = slot12_r;
    slot345_nxt = slot345_r;
    power_nxt = power_r;
    case (state_r)
      ahid_pkg::AHID_ST_START: begin
        slot12_nxt = {accy_in.slot1_code, accy_in.slot2_code};
        slot345_nxt[15:ahid_pkg::ACC_SLOT3_LSB] = accy_in.slot3_code;
        slot345_nxt[ahid_pkg::ACC_PLC_BIT] = accy_in.plc_fitted;
        slot345_nxt[ahid_pkg::ACC_MEM_BIT] = accy_in.mem_fitted;
        slot345_nxt[ahid_pkg::ACC_FB_LSB +: 2] = fb_code(accy_in.fieldbus_type);
        slot345_nxt[3:0] = ahid_pkg::ACC_LOW_FIXED;
        power_nxt[15:ahid_pkg::PWR_TOP_LSB] = ahid_pkg::PWR_TOP_FIXED;
        power_nxt[ahid_pkg::PWR_BRAKE_BIT] = ~power_in.brake_fitted;
        power_nxt[ahid_pkg::PWR_DCSPEC_BIT] = power_in.dc_special;
        power_nxt[ahid_pkg::PWR_CONV24_BIT] = ~power_in.conv24_fitted;
        power_nxt[ahid_pkg::PWR_RELAY_BIT] = power_in.relay_fitted;
        power_nxt[ahid_pkg::PWR_RFI_BIT] = power_in.rfi_fitted;
        power_nxt[ahid_pkg::PWR_VOLT_LSB +: 2] = power_in.volt_class;
        power_nxt[ahid_pkg::PWR_CUR_LSB +: 6] = power_in.current_code;
        state_nxt = ahid_pkg::AHID_ST_HOLD;
      end
      ahid_pkg::AHID_ST_HOLD: begin
        state_nxt = ahid_pkg::AHID_ST_HOLD;
      end
      default: begin
        state_nxt = ahid_pkg::AHID_ST_START;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      state_r <= ahid_pkg::AHID_ST_START;
      slot12_r <= ahid_pkg::RST_ID;
      slot345_r <= ahid_pkg::RST_ID;
      power_r <= ahid_pkg::RST_ID;
    end else begin
      state_r <= state_nxt;
      slot12_r <= slot12_nxt;
      slot345_r <= slot345_nxt;
      power_r <= power_nxt;
    end
  end

  // read port: data stands only in the cycle after the strobe; writes have
  // no decode at all, every register here is read-only
  always_comb begin
    rdata_nxt = ahid_pkg::RST_RDATA;
    if (bus_in.rd) begin
      case (bus_in.addr)
        ahid_pkg::OFF_SLOT12: rdata_nxt = slot12_r;
        ahid_pkg::OFF_SLOT345: rdata_nxt = slot345_r;
        ahid_pkg::OFF_POWER: rdata_nxt = power_r;
        ahid_pkg::OFF_STATUS: begin
          rdata_nxt[ahid_pkg::STAT_DONE_BIT] = (state_r == ahid_pkg::AHID_ST_HOLD);
        end
        default: rdata_nxt = ahid_pkg::RST_RDATA;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      rdata_r <= ahid_pkg::RST_RDATA;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign rdata = rdata_r;

  logic hold;
  assign hold = (state_r == ahid_pkg::AHID_ST_HOLD);

  // capture happens only on an edge that sees reset released; a start-state
  // edge still inside reset must not count as one
  logic capture_now;
  assign capture_now = reset_n && (state_r == ahid_pkg::AHID_ST_START);

  property p_slot12_capture;
    @(posedge ref_clk) disable iff (!reset_n)
    capture_now |=>
      slot12_r == {$past(accy_in.slot1_code), $past(accy_in.slot2_code)};
  endproperty
  a_slot12_capture: assert property (p_slot12_capture)
    else $error("slot12 register does not hold captured slot codes");

  property p_slot3_read;
    @(posedge ref_clk) disable iff (!reset_n)
    (hold && bus_in.rd && bus_in.addr == ahid_pkg::OFF_SLOT345) |=>
      rdata[15:8] == $past(slot345_r[15:8]) && rdata[3:0] == 4'h0;
  endproperty
  a_slot3_read: assert property (p_slot3_read)
    else $error("slot345 read returns wrong slot code");

  property p_plc_mem;
    @(posedge ref_clk) disable iff (!reset_n)
    (state_r == ahid_pkg::AHID_ST_START) ##1 hold[*3] |->
      slot345_r[7] == $past(accy_in.plc_fitted, 3) &&
      slot345_r[6] == $past(accy_in.mem_fitted, 3);
  endproperty
  a_plc_mem: assert property (p_plc_mem)
    else $error("controller or memory presence bit wrong");

  property p_fb_code;
    @(posedge ref_clk) disable iff (!reset_n)
    (capture_now && accy_in.fieldbus_type == 2'h3) |=>
      slot345_r[5:4] == 2'h0;
  endproperty
  a_fb_code: assert property (p_fb_code)
    else $error("undefined fieldbus kind reached register");

  property p_low_zero;
    @(posedge ref_clk) disable iff (!reset_n)
    slot345_r[3:0] == 4'h0;
  endproperty
  a_low_zero: assert property (p_low_zero)
    else $error("slot345 low nibble not zero");

  property p_write_ignored;
    @(posedge ref_clk) disable iff (!reset_n)
    (hold && bus_in.wr) |=> $stable(slot12_r) && $stable(slot345_r) && $stable(power_r);
  endproperty
  a_write_ignored: assert property (p_write_ignored)
    else $error("write changed a read-only register");

  property p_top_fixed;
    @(posedge ref_clk) disable iff (!reset_n)
    hold |-> power_r[15:13] == 3'h6;
  endproperty
  a_top_fixed: assert property (p_top_fixed)
    else $error("power bits 15:13 not 110");

  property p_inverted_bits;
    @(posedge ref_clk) disable iff (!reset_n)
    capture_now |=>
      power_r[12] != $past(power_in.brake_fitted) &&
      power_r[10] != $past(power_in.conv24_fitted);
  endproperty
  a_inverted_bits: assert property (p_inverted_bits)
    else $error("braking or converter bit has wrong sense");

  property p_direct_bits;
    @(posedge ref_clk) disable iff (!reset_n)
    capture_now |=>
      power_r[11] == $past(power_in.dc_special) &&
      power_r[9] == $past(power_in.relay_fitted) &&
      power_r[8] == $past(power_in.rfi_fitted);
  endproperty
  a_direct_bits: assert property (p_direct_bits)
    else $error("dc special, relay or filter bit wrong");

  property p_volt_cur;
    @(posedge ref_clk) disable iff (!reset_n)
    capture_now |=>
      power_r[7:0] == {$past(power_in.volt_class), $past(power_in.current_code)};
  endproperty
  a_volt_cur: assert property (p_volt_cur)
    else $error("voltage class or current code wrong");

  property p_hold_stable;
    @(posedge ref_clk) disable iff (!reset_n)
    hold |=> hold && $stable(power_r) && $stable(slot345_r) && $stable(slot12_r);
  endproperty
  a_hold_stable: assert property (p_hold_stable)
    else $error("captured values changed after start");

  property p_rd_only_next;
    @(posedge ref_clk) disable iff (!reset_n)
    !bus_in.rd |=> rdata == 16'h0000;
  endproperty
  a_rd_only_next: assert property (p_rd_only_next)
    else $error("read data present without a read");

  property p_capture_once;
    @(posedge ref_clk) disable iff (!reset_n)
    capture_now |=>
      hold;
  endproperty
  a_capture_once: assert property (p_capture_once)
    else $error("capture did not complete in one cycle");

  property p_reset_state;
    @(posedge ref_clk)
    !reset_n |=>
      !hold && rdata == ahid_pkg::RST_RDATA && slot12_r == ahid_pkg::RST_ID;
  endproperty
  a_reset_state: assert property (p_reset_state)
    else $error("reset did not restart the capture");

  property p_slot3_capture;
    @(posedge ref_clk) disable iff (!reset_n)
    capture_now |=>
      slot345_r[15:ahid_pkg::ACC_SLOT3_LSB] == $past(accy_in.slot3_code);
  endproperty
  a_slot3_capture: assert property (p_slot3_capture)
    else $error("slot 3 code not captured in high byte");

  property p_plc_bit;
    @(posedge ref_clk) disable iff (!reset_n)
    capture_now |=>
      slot345_r[ahid_pkg::ACC_PLC_BIT] == $past(accy_in.plc_fitted);
  endproperty
  a_plc_bit: assert property (p_plc_bit)
    else $error("controller presence bit wrong after capture");

  property p_mem_bit;
    @(posedge ref_clk) disable iff (!reset_n)
    capture_now |=>
      slot345_r[ahid_pkg::ACC_MEM_BIT] == $past(accy_in.mem_fitted);
  endproperty
  a_mem_bit: assert property (p_mem_bit)
    else $error("memory presence bit wrong after capture");

  property p_fb_active;
    @(posedge ref_clk) disable iff (!reset_n)
    capture_now && accy_in.fieldbus_type == ahid_pkg::FB_ACTIVE |=>
      slot345_r[ahid_pkg::ACC_FB_LSB +: 2] == ahid_pkg::FB_ACTIVE;
  endproperty
  a_fb_active: assert property (p_fb_active)
    else $error("active fieldbus module not coded 01");

  property p_fb_passive;
    @(posedge ref_clk) disable iff (!reset_n)
    capture_now && accy_in.fieldbus_type == ahid_pkg::FB_PASSIVE |=>
      slot345_r[ahid_pkg::ACC_FB_LSB +: 2] == ahid_pkg::FB_PASSIVE;
  endproperty
  a_fb_passive: assert property (p_fb_passive)
    else $error("passive fieldbus module not coded 10");

  property p_fb_none;
    @(posedge ref_clk) disable iff (!reset_n)
    capture_now && accy_in.fieldbus_type == ahid_pkg::FB_NONE |=>
      slot345_r[ahid_pkg::ACC_FB_LSB +: 2] == ahid_pkg::FB_NONE;
  endproperty
  a_fb_none: assert property (p_fb_none)
    else $error("absent fieldbus module not coded 00");

  property p_low_byte;
    @(posedge ref_clk) disable iff (!reset_n)
    capture_now && !accy_in.plc_fitted && !accy_in.mem_fitted &&
      accy_in.fieldbus_type == ahid_pkg::FB_NONE |=>
      slot345_r[7:0] == 8'h00;
  endproperty
  a_low_byte: assert property (p_low_byte)
    else $error("slot345 low byte set with no module fitted");

  property p_dcspec_bit;
    @(posedge ref_clk) disable iff (!reset_n)
    capture_now |=>
      power_r[ahid_pkg::PWR_DCSPEC_BIT] == $past(power_in.dc_special);
  endproperty
  a_dcspec_bit: assert property (p_dcspec_bit)
    else $error("special dc hardware bit wrong");

  property p_conv24_bit;
    @(posedge ref_clk) disable iff (!reset_n)
    capture_now |=>
      power_r[ahid_pkg::PWR_CONV24_BIT] == !$past(power_in.conv24_fitted);
  endproperty
  a_conv24_bit: assert property (p_conv24_bit)
    else $error("24 V converter bit has wrong sense");

  property p_rfi_bit;
    @(posedge ref_clk) disable iff (!reset_n)
    capture_now |=>
      power_r[ahid_pkg::PWR_RFI_BIT] == $past(power_in.rfi_fitted);
  endproperty
  a_rfi_bit: assert property (p_rfi_bit)
    else $error("suppression filter bit wrong");

  property p_volt_field;
    @(posedge ref_clk) disable iff (!reset_n)
    capture_now |=>
      power_r[ahid_pkg::PWR_VOLT_LSB +: 2] == $past(power_in.volt_class);
  endproperty
  a_volt_field: assert property (p_volt_field)
    else $error("voltage class field wrong");

  property p_current_field;
    @(posedge ref_clk) disable iff (!reset_n)
    capture_now |=>
      power_r[ahid_pkg::PWR_CUR_LSB +: 6] == $past(power_in.current_code);
  endproperty
  a_current_field: assert property (p_current_field)
    else $error("rated current code field wrong");

  property p_top_capture;
    @(posedge ref_clk) disable iff (!reset_n)
    capture_now |=>
      power_r[15:ahid_pkg::PWR_TOP_LSB] == ahid_pkg::PWR_TOP_FIXED;
  endproperty
  a_top_capture: assert property (p_top_capture)
    else $error("power top bits not 110 after capture");

  property p_slot12_read;
    @(posedge ref_clk) disable iff (!reset_n)
    hold && bus_in.rd && bus_in.addr == ahid_pkg::OFF_SLOT12 |=>
      rdata == $past(slot12_r);
  endproperty
  a_slot12_read: assert property (p_slot12_read)
    else $error("slot12 read returns wrong word");

  property p_power_read;
    @(posedge ref_clk) disable iff (!reset_n)
    hold && bus_in.rd && bus_in.addr == ahid_pkg::OFF_POWER |=>
      rdata == $past(power_r);
  endproperty
  a_power_read: assert property (p_power_read)
    else $error("power read returns wrong word");

  property p_status_read;
    @(posedge ref_clk) disable iff (!reset_n)
    bus_in.rd && bus_in.addr == ahid_pkg::OFF_STATUS |=>
      rdata == {15'h0000, $past(hold)};
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("status read does not show capture state");

  property p_unmapped_read;
    @(posedge ref_clk) disable iff (!reset_n)
    bus_in.rd && bus_in.addr > ahid_pkg::OFF_STATUS |=>
      rdata == ahid_pkg::RST_RDATA;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read)
    else $error("unmapped read returns nonzero data");

endmodule

// >>> tb/tb_ahid_regs.sv
`timescale 1ns/1ps
module tb_ahid_regs;
  logic ref_clk;
  logic reset_n;
  ahid_pkg::ahid_accy_t accy_in;
  ahid_pkg::ahid_power_t power_in;
  ahid_pkg::ahid_bus_t bus_in;
  logic [15:0] rdata;
  int n_errors;
  int checks_done;
  logic [12:0] pv [4] = '{13'h0000, 13'h1F7F, 13'h0A55, 13'h152A};

  ahid_regs i_dut (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .accy_in(accy_in),
    .power_in(power_in),
    .bus_in(bus_in),
    .rdata(rdata)
  );

  always #50 ref_clk = ~ref_clk;

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, got);
      n_errors++;
    end
  endtask

  function automatic logic [15:0] e345(input ahid_pkg::ahid_accy_t a);
    logic [1:0] f;
    f = (a.fieldbus_type == 2'h3) ? 2'h0 : a.fieldbus_type;
    return {a.slot3_code, a.plc_fitted, a.mem_fitted, f, 4'h0};
  endfunction

  function automatic logic [15:0] epwr(input ahid_pkg::ahid_power_t p);
    return {3'h6, ~p.brake_fitted, p.dc_special, ~p.conv24_fitted, p.relay_fitted,
      p.rfi_fitted, p.volt_class, p.current_code};
  endfunction

  // one read; data must stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [15:0] exp, input string what);
    @(posedge ref_clk);
    bus_in <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus_in.rd <= 1'b0;
    #1;
    chk(what, exp, rdata);
    @(posedge ref_clk);
    #1;
    chk({what, " idle"}, 16'h0000, rdata);
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    bus_in <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus_in.wr <= 1'b0;
  endtask

  task automatic restart(input ahid_pkg::ahid_accy_t a, input ahid_pkg::ahid_power_t p);
    @(posedge ref_clk);
    reset_n <= 1'b0;
    accy_in <= a;
    power_in <= p;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
  endtask

  // every fieldbus code, both states of each presence flag, several power words
  task automatic s_codes();
    ahid_pkg::ahid_accy_t a;
    ahid_pkg::ahid_power_t p;
    for (int i = 0; i < 4; i++) begin
      a = {8'h5A, 8'hA5, 8'h81, 4'(i * 5)};
      p = pv[i];
      restart(a, p);
      rd(ahid_pkg::OFF_SLOT12, {a.slot1_code, a.slot2_code}, "slot12");
      rd(ahid_pkg::OFF_SLOT345, e345(a), "slot345");
      rd(ahid_pkg::OFF_POWER, epwr(p), "power");
      rd(ahid_pkg::OFF_STATUS, 16'h0001, "status");
    end
    rd(4'h4, 16'h0000, "unmapped 4");
    rd(4'hF, 16'h0000, "unmapped F");
  endtask

  // back-to-back reads, each answered in the next cycle only
  task automatic s_b2b();
    @(posedge ref_clk);
    bus_in <= '{addr: ahid_pkg::OFF_SLOT345, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus_in.addr <= ahid_pkg::OFF_POWER;
    #1;
    chk("b2b slot345", e345(accy_in), rdata);
    @(posedge ref_clk);
    bus_in.rd <= 1'b0;
    #1;
    chk("b2b power", epwr(power_in), rdata);
    @(posedge ref_clk);
    #1;
    chk("b2b idle", 16'h0000, rdata);
  endtask

  // writes and later input changes must leave the captured words alone
  task automatic s_hold();
    logic [15:0] e0;
    logic [15:0] e1;
    logic [15:0] e2;
    e0 = {accy_in.slot1_code, accy_in.slot2_code};
    e1 = e345(accy_in);
    e2 = epwr(power_in);
    for (int a = 0; a < 4; a++) wr(4'(a), 16'hFFFF);
    accy_in <= ~accy_in;
    power_in <= ~power_in;
    repeat (3) @(posedge ref_clk);
    rd(ahid_pkg::OFF_SLOT12, e0, "held slot12");
    rd(ahid_pkg::OFF_SLOT345, e1, "held slot345");
    rd(ahid_pkg::OFF_POWER, e2, "held power");
    rd(ahid_pkg::OFF_STATUS, 16'h0001, "held status");
  endtask

  // a read in the capture cycle still sees capture pending, then fresh values
  task automatic s_early();
    @(posedge ref_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    bus_in <= '{addr: ahid_pkg::OFF_STATUS, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus_in.rd <= 1'b0;
    #1;
    chk("early status", 16'h0000, rdata);
    rd(ahid_pkg::OFF_STATUS, 16'h0001, "late status");
    rd(ahid_pkg::OFF_SLOT345, e345(accy_in), "recaptured slot345");
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    ref_clk = 1'b0;
    reset_n = 1'b0;
    accy_in = '0;
    power_in = '0;
    bus_in = '0;
    n_errors = 0;
    checks_done = 0;
    repeat (20) @(posedge ref_clk);
    reset_n <= 1'b1;
    s_codes();
    s_b2b();
    s_hold();
    s_early();
    close_out();
  end
endmodule
